// ===== ssd_pkg.sv
package ssd_pkg;

  // Instruction field positions
  localparam int OP_HI      = 62;
  localparam int OP_LO      = 59;
  localparam int REL_BIT    = 58;
  localparam int HINT_BIT   = 63;
  localparam int REGO_HI    = 57;
  localparam int REGO_LO    = 55;
  localparam int RDST_HI    = 54;
  localparam int RDST_LO    = 53;
  localparam int RSRC_HI    = 52;
  localparam int RSRC_LO    = 51;
  localparam int EXT_HI     = 47;
  localparam int EXT_LO     = 44;
  localparam int IMM_HI     = 43;
  localparam int IMM_LO     = 31;
  localparam int IMM_W      = 13;
  localparam int BYTE_SHIFT = 3;

  // Operation codes
  localparam logic [3:0] OPC_EXT      = 4'h0;
  localparam logic [3:0] OPC_LTZ      = 4'h1;
  localparam logic [3:0] OPC_NEZ      = 4'h2;
  localparam logic [3:0] OPC_GEZ      = 4'h3;
  localparam logic [3:0] OPC_CALL     = 4'h4;
  localparam logic [3:0] OPC_JUMP     = 4'h5;
  localparam logic [3:0] OPC_GTZ      = 4'h6;
  localparam logic [3:0] OPC_EQZ      = 4'h7;
  localparam logic [3:0] OPC_LEZ      = 4'hC;
  localparam logic [3:0] OPC_NZ_DEC   = 4'hD;
  localparam logic [3:0] OPC_Z_DEC    = 4'hE;
  localparam logic [3:0] OPC_DEBUG    = 4'hF;

  // Extended operation codes
  localparam logic [3:0] EXT_NOP      = 4'h0;
  localparam logic [3:0] EXT_MOVE     = 4'h1;
  localparam logic [3:0] EXT_RJUMP    = 4'h2;
  localparam logic [3:0] EXT_RCALL    = 4'h3;

  // Port selector codes
  localparam logic [2:0] SEL_NONE     = 3'h0;
  localparam logic [2:0] SEL_PROC     = 3'h1;
  localparam logic [2:0] SEL_WEST     = 3'h2;
  localparam logic [2:0] SEL_SOUTH    = 3'h3;
  localparam logic [2:0] SEL_EAST     = 3'h4;
  localparam logic [2:0] SEL_NORTH    = 3'h5;
  localparam logic [2:0] SEL_XDOM     = 3'h6;
  localparam logic [2:0] SEL_REGFILE  = 3'h7;

  // Widths and reset values
  localparam int          DATA_W      = 32;
  localparam int          PC_W        = 13;
  localparam logic [31:0] DATA_RST    = 32'h0000_0000;

  // Decoded operand port names
  typedef enum logic [3:0] {
    port_none,
    port_proc_out,
    west_in_port,
    south_in_port,
    east_in_port,
    north_in_port,
    cross_domain_in_one,
    second_net_west_in,
    second_net_south_in,
    second_net_east_in,
    second_net_north_in,
    cross_domain_in_two,
    port_regfile
  } ssd_port_t;

endpackage

// ===== ssd_port_map.sv
`timescale 1ns/100ps
module ssd_port_map
  import ssd_pkg::*;
#(
  parameter bit SECONDARY = 1'b0
) (
  input  wire logic [2:0]         sel_i,
  output ssd_pkg::ssd_port_t      port_o
);

  // Selector to port name, network ports depend on switch
  always_comb begin
    case (sel_i)
      SEL_NONE:    port_o = port_none;
      SEL_PROC:    port_o = port_proc_out;
      SEL_WEST:    port_o = SECONDARY ? second_net_west_in  : west_in_port;
      SEL_SOUTH:   port_o = SECONDARY ? second_net_south_in : south_in_port;
      SEL_EAST:    port_o = SECONDARY ? second_net_east_in  : east_in_port;
      SEL_NORTH:   port_o = SECONDARY ? second_net_north_in : north_in_port;
      SEL_XDOM:    port_o = SECONDARY ? cross_domain_in_two : cross_domain_in_one;
      SEL_REGFILE: port_o = port_regfile;
      default:     port_o = port_none;
    endcase
  end

endmodule // ssd_port_map

// ===== ssd_decode.sv
`timescale 1ns/100ps
module ssd_decode
  import ssd_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   instr_valid_i,
  input  wire logic [63:0]            instr_i,
  input  wire logic [ssd_pkg::PC_W-1:0]   pc_i,
  input  wire logic [ssd_pkg::DATA_W-1:0] operand_i,
  input  wire logic [2:0]             route_sec_sel_i,
  input  wire logic                   route_reg_used_i,
  input  wire logic [1:0]             route_reg_i,
  input  wire logic                   xd_out_one_valid_i,
  input  wire logic [ssd_pkg::DATA_W-1:0] xd_out_one_i,
  input  wire logic                   xd_out_two_valid_i,
  input  wire logic [ssd_pkg::DATA_W-1:0] xd_out_two_i,
  output ssd_pkg::ssd_port_t          operand_port_o,
  output ssd_pkg::ssd_port_t          route_sec_port_o,
  output logic                        reg_rd_en_o,
  output logic [1:0]                  reg_rd_addr_o,
  output logic                        reg_wr_en_o,
  output logic [1:0]                  reg_wr_addr_o,
  output logic [ssd_pkg::DATA_W-1:0]  reg_wr_data_o,
  output logic                        jump_o,
  output logic [ssd_pkg::PC_W-1:0]    jump_target_o,
  output logic                        debug_o,
  output logic [ssd_pkg::IMM_W-1:0]   debug_immediate_o,
  output logic                        illegal_o,
  output logic                        xd_in_two_valid_o,
  output logic [ssd_pkg::DATA_W-1:0]  xd_in_two_o,
  output logic                        xd_in_one_valid_o,
  output logic [ssd_pkg::DATA_W-1:0]  xd_in_one_o
);

  // Field extraction
  logic [3:0]             op_code;
  logic                   rel_flag;
  logic                   hint_bit;
  logic [2:0]             operand_sel;
  logic [1:0]             rdst;
  logic [1:0]             rsrc;
  logic [3:0]             extended_op_selector;
  logic [IMM_W-1:0]       target_byte_offset;
  logic signed [DATA_W-1:0] opnd_s;
  logic [DATA_W-1:0]      dec_value;
  logic [PC_W-1:0]        return_addr;
  ssd_port_t              opnd_port;
  ssd_port_t              sec_port;

  assign op_code              = instr_i[OP_HI:OP_LO];
  assign rel_flag             = instr_i[REL_BIT];
  assign hint_bit             = instr_i[HINT_BIT];
  assign operand_sel          = instr_i[REGO_HI:REGO_LO];
  assign rdst                 = instr_i[RDST_HI:RDST_LO];
  assign rsrc                 = instr_i[RSRC_HI:RSRC_LO];
  assign extended_op_selector = instr_i[EXT_HI:EXT_LO];
  assign target_byte_offset   = instr_i[IMM_HI:IMM_LO];
  assign opnd_s               = $signed(operand_i);
  assign dec_value            = operand_i - DATA_W'(1);
  assign return_addr          = pc_i + PC_W'(1);

  // Port selector decoders for both switches
  ssd_port_map #(
    .SECONDARY (1'b0)
  ) u_prim_map (
    .sel_i     (operand_sel),
    .port_o    (opnd_port)
  );

  ssd_port_map #(
    .SECONDARY (1'b1)
  ) u_sec_map (
    .sel_i     (route_sec_sel_i),
    .port_o    (sec_port)
  );

  // Next values of the decoded instruction
  ssd_port_t              next_operand_port;
  ssd_port_t              next_route_sec_port;
  logic                   next_reg_rd_en;
  logic [1:0]             next_reg_rd_addr;
  logic                   next_reg_wr_en;
  logic [1:0]             next_reg_wr_addr;
  logic [DATA_W-1:0]      next_reg_wr_data;
  logic                   next_jump;
  logic [PC_W-1:0]        next_jump_target;
  logic                   next_debug;
  logic [IMM_W-1:0]       next_debug_immediate;
  logic                   next_illegal;
  logic                   rd_clash;
  logic                   dec_bad;
  logic                   cond;
  logic                   is_cond;

  always_comb begin
    next_operand_port    = port_none;
    next_route_sec_port  = port_none;
    next_reg_rd_en       = 1'b0;
    next_reg_rd_addr     = 2'h0;
    next_reg_wr_en       = 1'b0;
    next_reg_wr_addr     = rdst;
    next_reg_wr_data     = DATA_RST;
    next_jump            = 1'b0;
    // Relative forms are already absolute once stored
    next_jump_target     = PC_W'(target_byte_offset);
    next_debug           = 1'b0;
    next_debug_immediate = '0;
    next_illegal         = 1'b0;
    is_cond              = 1'b0;
    cond                 = 1'b0;
    rd_clash             = 1'b0;
    dec_bad              = 1'b0;
    if (instr_valid_i) begin
      next_route_sec_port = sec_port;
      // Sign and zero tests on the operand
      case (op_code)
        OPC_LTZ: begin
          is_cond = 1'b1;
          cond    = opnd_s < 0;
        end
        OPC_NEZ: begin
          is_cond = 1'b1;
          cond    = operand_i != '0;
        end
        OPC_GEZ: begin
          is_cond = 1'b1;
          cond    = opnd_s >= 0;
        end
        OPC_GTZ: begin
          is_cond = 1'b1;
          cond    = opnd_s > 0;
        end
        OPC_EQZ: begin
          is_cond = 1'b1;
          cond    = operand_i == '0;
        end
        OPC_LEZ: begin
          is_cond = 1'b1;
          cond    = opnd_s <= 0;
        end
        default: begin
          is_cond = 1'b0;
          cond    = 1'b0;
        end
      endcase
      // Decrementing forms need regfile operand and distinct registers
      dec_bad = (op_code == OPC_Z_DEC || op_code == OPC_NZ_DEC) &&
                (operand_sel != SEL_REGFILE || rsrc == rdst);
      // Single regfile read port: route read must match operand read
      rd_clash = route_reg_used_i && operand_sel == SEL_REGFILE &&
                 route_reg_i != rsrc;
      next_illegal = dec_bad || rd_clash;
      if (!next_illegal) begin
        if (route_reg_used_i) begin
          next_reg_rd_en   = 1'b1;
          next_reg_rd_addr = route_reg_i;
        end
        if (is_cond) begin
          next_operand_port = opnd_port;
          next_jump         = cond;
        end else begin
          case (op_code)
            OPC_Z_DEC, OPC_NZ_DEC: begin
              next_operand_port = port_regfile;
              next_reg_rd_en    = 1'b1;
              next_reg_rd_addr  = rsrc;
              next_reg_wr_en    = 1'b1;
              next_reg_wr_data  = dec_value;
              next_jump         = (op_code == OPC_Z_DEC) ? (operand_i == '0)
                                                         : (operand_i != '0);
            end
            OPC_CALL: begin
              if (hint_bit) begin
                next_jump        = 1'b1;
                next_reg_wr_en   = 1'b1;
                next_reg_wr_data = DATA_W'(return_addr);
              end
            end
            OPC_JUMP: begin
              next_jump = hint_bit;
            end
            OPC_DEBUG: begin
              if (!rel_flag && !hint_bit) begin
                next_debug           = 1'b1;
                next_debug_immediate = target_byte_offset;
              end
            end
            OPC_EXT: begin
              case (extended_op_selector)
                EXT_NOP: begin
                  next_reg_wr_en = 1'b0;
                end
                EXT_MOVE: begin
                  next_operand_port = opnd_port;
                  next_reg_wr_en    = 1'b1;
                  next_reg_wr_data  = operand_i;
                end
                EXT_RJUMP: begin
                  next_operand_port = opnd_port;
                  next_jump         = 1'b1;
                  next_jump_target  = operand_i[PC_W-1:0];
                end
                EXT_RCALL: begin
                  next_operand_port = opnd_port;
                  next_jump         = 1'b1;
                  next_jump_target  = operand_i[PC_W-1:0];
                  next_reg_wr_en    = 1'b1;
                  next_reg_wr_data  = DATA_W'(return_addr);
                end
                default: begin
                  next_reg_wr_en = 1'b0;
                end
              endcase
            end
            default: begin
              next_jump = 1'b0;
            end
          endcase
        end
        if (next_operand_port == port_regfile) begin
          next_reg_rd_en   = 1'b1;
          next_reg_rd_addr = rsrc;
        end
      end
    end
  end

  // Decoded instruction registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      operand_port_o    <= port_none;
      route_sec_port_o  <= port_none;
      reg_rd_en_o       <= 1'b0;
      reg_rd_addr_o     <= 2'h0;
      reg_wr_en_o       <= 1'b0;
      reg_wr_addr_o     <= 2'h0;
      reg_wr_data_o     <= DATA_RST;
      jump_o            <= 1'b0;
      jump_target_o     <= '0;
      debug_o           <= 1'b0;
      debug_immediate_o <= '0;
      illegal_o         <= 1'b0;
    end else begin
      operand_port_o    <= next_operand_port;
      route_sec_port_o  <= next_route_sec_port;
      reg_rd_en_o       <= next_reg_rd_en;
      reg_rd_addr_o     <= next_reg_rd_addr;
      reg_wr_en_o       <= next_reg_wr_en;
      reg_wr_addr_o     <= next_reg_wr_addr;
      reg_wr_data_o     <= next_reg_wr_data;
      jump_o            <= next_jump;
      jump_target_o     <= next_jump_target;
      debug_o           <= next_debug;
      debug_immediate_o <= next_debug_immediate;
      illegal_o         <= next_illegal;
    end
  end

  // Cross-domain words land on the other domain's input
  logic                   next_xd_in_two_valid;
  logic [DATA_W-1:0]      next_xd_in_two;
  logic                   next_xd_in_one_valid;
  logic [DATA_W-1:0]      next_xd_in_one;

  always_comb begin
    next_xd_in_two_valid = xd_out_one_valid_i;
    next_xd_in_two       = xd_out_one_valid_i ? xd_out_one_i : xd_in_two_o;
    next_xd_in_one_valid = xd_out_two_valid_i;
    next_xd_in_one       = xd_out_two_valid_i ? xd_out_two_i : xd_in_one_o;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      xd_in_two_valid_o <= 1'b0;
      xd_in_two_o       <= DATA_RST;
      xd_in_one_valid_o <= 1'b0;
      xd_in_one_o       <= DATA_RST;
    end else begin
      xd_in_two_valid_o <= next_xd_in_two_valid;
      xd_in_two_o       <= next_xd_in_two;
      xd_in_one_valid_o <= next_xd_in_one_valid;
      xd_in_one_o       <= next_xd_in_one;
    end
  end

endmodule // ssd_decode

// ===== ssd_decode_asserts.sv
`timescale 1ns/100ps
module ssd_decode_asserts
  import ssd_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        instr_valid_i,
  input wire logic [63:0] instr_i,
  input wire logic [12:0] pc_i,
  input wire logic [31:0] operand_i,
  input wire logic        route_reg_used_i,
  input wire logic        xd_out_one_valid_i,
  input wire logic [31:0] xd_out_one_i,
  input wire logic        xd_out_two_valid_i,
  input wire logic [31:0] xd_out_two_i,
  input wire logic        reg_wr_en_o,
  input wire logic [31:0] reg_wr_data_o,
  input wire logic        jump_o,
  input wire logic [12:0] jump_target_o,
  input wire logic        debug_o,
  input wire logic [12:0] debug_immediate_o,
  input wire logic        illegal_o,
  input wire logic        xd_in_two_valid_o,
  input wire logic [31:0] xd_in_two_o,
  input wire logic        xd_in_one_valid_o,
  input wire logic [31:0] xd_in_one_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Instruction fields seen by the properties
  wire logic [3:0] opc = instr_i[62:59];
  wire logic       take = instr_valid_i && !rst_i;
  wire logic       dec_ok = (opc == 4'hD || opc == 4'hE) && instr_i[57:55] == 3'h7
                            && instr_i[54:53] != instr_i[52:51] && !route_reg_used_i;

  chk_xd_one_two:
  assert property (xd_out_one_valid_i |=> xd_in_two_valid_o && xd_in_two_o == $past(xd_out_one_i))
    else $error("cross word one to two lost");
  chk_xd_two_one:
  assert property (xd_out_two_valid_i |=> xd_in_one_valid_o && xd_in_one_o == $past(xd_out_two_i))
    else $error("cross word two to one lost");
  chk_illegal_quiet:
  assert property (illegal_o |-> !reg_wr_en_o && !jump_o)
    else $error("refused instruction took effect");
  chk_dec_write:
  assert property (take && dec_ok |=> reg_wr_en_o && reg_wr_data_o == $past(operand_i) - 32'h1)
    else $error("decrement write wrong");
  chk_eqz_branch:
  assert property (take && opc == 4'h7 |=> jump_o == ($past(operand_i) == 32'h0))
    else $error("zero test branch wrong");
  chk_ltz_sign:
  assert property (take && opc == 4'h1 |=> jump_o == $past(operand_i[31]))
    else $error("sign test branch wrong");
  chk_debug_imm:
  assert property (take && instr_i[63:58] == 6'h1E |=> debug_o
                   && debug_immediate_o == $past(instr_i[43:31]))
    else $error("debug immediate wrong");
  chk_unassigned_nop:
  assert property (take && opc inside {[4'h8:4'hB]} |=> !jump_o && !reg_wr_en_o && !debug_o)
    else $error("unassigned code acted");
  chk_call_link:
  assert property (take && instr_i[63:59] == 5'h14 |=> jump_o && jump_target_o ==
                   $past(instr_i[43:31]) && reg_wr_data_o == {19'h0, $past(pc_i) + 13'h1})
    else $error("call target or link wrong");
endmodule // ssd_decode_asserts

bind ssd_decode ssd_decode_asserts ssd_decode_asserts_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .pc_i(pc_i), .operand_i(operand_i), .route_reg_used_i(route_reg_used_i),
  .xd_out_one_valid_i(xd_out_one_valid_i), .xd_out_one_i(xd_out_one_i),
  .xd_out_two_valid_i(xd_out_two_valid_i), .xd_out_two_i(xd_out_two_i),
  .reg_wr_en_o(reg_wr_en_o), .reg_wr_data_o(reg_wr_data_o), .jump_o(jump_o),
  .jump_target_o(jump_target_o), .debug_o(debug_o), .debug_immediate_o(debug_immediate_o),
  .illegal_o(illegal_o), .xd_in_two_valid_o(xd_in_two_valid_o), .xd_in_two_o(xd_in_two_o),
  .xd_in_one_valid_o(xd_in_one_valid_o), .xd_in_one_o(xd_in_one_o)
);

// ===== ssd_far_model.sv
`timescale 1ns/100ps
module ssd_far_model (
  input  wire logic        ref_clk_i,
  input  wire logic [2:0]  sel_i,
  input  wire logic [1:0]  rsrc_i,
  input  wire logic        wr_en_i,
  input  wire logic [1:0]  wr_addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic [31:0] net_i,
  output logic      [31:0] operand_o
);
  logic [31:0] rf [4];
  logic        tog = 1'b0;
  // Register file takes the decoder's write one edge after it is issued
  always_ff @(posedge ref_clk_i) begin
    tog <= ~tog;
    if (wr_en_i) rf[wr_addr_i] <= wr_data_i;
  end
  // One read port: the single named register, with the pending write forwarded
  always_comb begin
    if (sel_i == 3'h7) operand_o = (wr_en_i && wr_addr_i == rsrc_i) ? wr_data_i : rf[rsrc_i];
    else if (sel_i == 3'h0) operand_o = {16{2'h2}} ^ {32{tog}}; // Nothing selected
    else operand_o = net_i;
  end
endmodule // ssd_far_model

// ===== static_switch_instr_decode_tb.sv
`timescale 1ns/100ps
module static_switch_instr_decode_tb;
  import ssd_pkg::*;
  logic        ref_clk_i, rst_i, instr_valid_i, route_reg_used_i, x1v, x2v;
  logic [63:0] instr_i;
  logic [12:0] pc_i, jt, dimm;
  logic [31:0] operand_i, net, x1d, x2d, wd, i2d, i1d;
  logic [2:0]  route_sec_sel_i;
  logic [1:0]  route_reg_i, ra, wa;
  logic        rd_en, wr_en, jmp, dbg, ill, i2v, i1v;
  ssd_port_t   op_port, sec_port;
  int          n_fail, check_count, seed, rf[4];
  int          e_jmp, e_wr, e_dbg, e_ill, e_pchk, e_port, e_sec, e_i2v, e_i1v, e_rd;
  logic [31:0] e_wd, e_i2d, e_i1d;
  logic [12:0] e_jt, e_di;
  logic [1:0]  e_wa, e_ra;
  logic        rru;
  logic [1:0]  rrn;

  ssd_decode ssd_decode_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .pc_i(pc_i), .operand_i(operand_i), .route_sec_sel_i(route_sec_sel_i),
    .route_reg_used_i(route_reg_used_i), .route_reg_i(route_reg_i), .xd_out_one_valid_i(x1v),
    .xd_out_one_i(x1d), .xd_out_two_valid_i(x2v), .xd_out_two_i(x2d), .operand_port_o(op_port),
    .route_sec_port_o(sec_port), .reg_rd_en_o(rd_en), .reg_rd_addr_o(ra), .reg_wr_en_o(wr_en),
    .reg_wr_addr_o(wa), .reg_wr_data_o(wd), .jump_o(jmp), .jump_target_o(jt), .debug_o(dbg),
    .debug_immediate_o(dimm), .illegal_o(ill), .xd_in_two_valid_o(i2v), .xd_in_two_o(i2d),
    .xd_in_one_valid_o(i1v), .xd_in_one_o(i1d));
  ssd_far_model ssd_far_model_i (.ref_clk_i(ref_clk_i), .sel_i(instr_i[57:55]),
    .rsrc_i(instr_i[52:51]), .wr_en_i(wr_en), .wr_addr_i(wa), .wr_data_i(wd), .net_i(net),
    .operand_o(operand_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [63:0] mk(input logic [3:0] op, input logic h, r,
      input logic [2:0] sel, input logic [1:0] rd, rs, input logic [3:0] ex, input logic [12:0] im);
    mk = {h, op, r, sel, rd, rs, 2'h0, ex, im, 31'h0};
  endfunction

  // Compare last cycle's prediction, then apply and predict the next instruction
  task automatic step(input logic [63:0] ins, input logic [31:0] nw, input logic v, r);
    logic [3:0] op;
    logic [2:0] sel, s;
    int opv;
    @(negedge ref_clk_i);
    cmp(jmp, e_jmp);
    if (e_jmp) cmp(jt, e_jt);
    cmp(wr_en, e_wr);
    if (e_wr) cmp(wd, e_wd);
    if (e_wr) cmp(32'(wa), 32'(e_wa));
    cmp(rd_en, e_rd);
    if (e_rd) cmp(32'(ra), 32'(e_ra));
    cmp(dbg, e_dbg);
    if (e_dbg) cmp(dimm, e_di);
    cmp(ill, e_ill);
    if (e_pchk) cmp(op_port, e_port);
    cmp(sec_port, e_sec);
    cmp({i2v, i1v}, {e_i2v[0], e_i1v[0]});
    cmp(i2d, e_i2d);
    cmp(i1d, e_i1d);
    instr_i = ins; net = nw; instr_valid_i = v; rst_i = r;
    route_reg_used_i = rru; route_reg_i = rrn;
    pc_i = 13'({$random(seed)} % 4000); route_sec_sel_i = 3'($random(seed));
    x1v = 1'($random(seed)); x1d = $random(seed); x2v = 1'($random(seed)); x2d = $random(seed);
    op = ins[62:59]; sel = ins[57:55]; s = route_sec_sel_i;
    #1; // Far side settles; an unselected port shows its idle pattern
    opv = (sel == 3'h7) ? rf[ins[52:51]] : int'(operand_i);
    e_jmp = 0; e_wr = 0; e_dbg = 0; e_ill = 0; e_pchk = 0; e_port = 0; e_rd = 0;
    e_jt = ins[43:31]; e_wa = ins[54:53]; e_di = ins[43:31];
    e_i2v = !r && x1v; e_i1v = !r && x2v;
    e_i2d = r ? 32'h0 : x1v ? x1d : e_i2d;
    e_i1d = r ? 32'h0 : x2v ? x2d : e_i1d;
    e_sec = (r || !v) ? 0 : (s < 2) ? s : (s == 7) ? 12 : s + 5;
    if (v && !r) begin
      e_pchk = 1;
      case (op)
        4'h1: e_jmp = opv < 0;
        4'h2: e_jmp = opv != 0;
        4'h3: e_jmp = opv >= 0;
        4'h6: e_jmp = opv > 0;
        4'h7: e_jmp = opv == 0;
        4'hC: e_jmp = opv <= 0;
        4'h4: begin e_pchk = 0; e_jmp = ins[63]; e_wr = ins[63]; e_wd = 32'(pc_i) + 1; end
        4'h5: begin e_pchk = 0; e_jmp = ins[63]; end
        4'hD, 4'hE: begin
          e_ill = sel != 3'h7 || ins[52:51] == ins[54:53] || (rru && rrn != ins[52:51]);
          e_wr = !e_ill; e_wd = opv - 1; e_pchk = !e_ill;
          e_jmp = !e_ill && ((op == 4'hE) == (opv == 0));
        end
        4'hF: begin e_pchk = 0; e_dbg = ins[63:58] == 6'h1E; end
        4'h0: case (ins[47:44])
            4'h1: begin e_wr = 1; e_wd = opv; end
            4'h2: begin e_jmp = 1; e_jt = 13'(opv); end
            4'h3: begin e_jmp = 1; e_jt = 13'(opv); e_wr = 1; e_wd = 32'(pc_i) + 1; end
            default: e_pchk = 0;
          endcase
        default: e_pchk = 0;
      endcase
      if (sel == 3'h7 && rru && rrn != ins[52:51] && e_pchk) begin
        e_ill = 1; e_wr = 0; e_jmp = 0; e_pchk = 0;
      end
      // Single read port: operand read wins the number, else the route's
      e_rd = !e_ill && (rru || (e_pchk && sel == 3'h7));
      e_ra = (e_pchk && sel == 3'h7) ? ins[52:51] : rrn;
      e_port = (sel == 3'h7) ? 12 : sel;
      if (!e_pchk && sel == 3'h0) e_pchk = 1;
      if (e_wr) rf[e_wa] = e_wd;
    end
  endtask

  initial begin
    int vals[5] = '{0, 1, -1, 32'h8000_0000, 32'h7FFF_FFFF};
    logic [3:0] ops[6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hC};
    logic [63:0] ins;
    seed = 32'h9b5f; n_fail = 0; check_count = 0; rru = 0; rrn = 0; net = 0;
    rst_i = 1; instr_valid_i = 0; instr_i = 0; pc_i = 0; route_sec_sel_i = 0;
    route_reg_used_i = 0; route_reg_i = 0; x1v = 0; x1d = 0; x2v = 0; x2d = 0;
    e_i2d = 0; e_i1d = 0;
    repeat (4) step(0, 0, 0, 1);
    step(mk(0, 0, 0, 2, 1, 0, 1, 0), 5, 1, 0);
    step(mk(0, 0, 0, 6, 2, 0, 1, 0), 0, 1, 0);
    step(mk(0, 0, 0, 5, 3, 0, 1, 0), 32'h8000_0000, 1, 0);
    step(mk(4'hE, 0, 1, 7, 0, 1, 0, 13'h12), 0, 1, 0);
    step(mk(4'hD, 1, 0, 7, 1, 2, 0, 13'h34), 0, 1, 0);
    step(mk(4'hE, 1, 1, 7, 3, 2, 0, 13'h1FFF), 0, 1, 0);
    step(mk(4'hD, 0, 0, 7, 2, 0, 0, 13'h0), 0, 1, 0);
    step(mk(4'hE, 0, 0, 2, 2, 0, 0, 13'h5), 9, 1, 0);
    step(mk(4'hD, 0, 0, 7, 1, 1, 0, 13'h5), 0, 1, 0);
    rru = 1; rrn = 3;
    step(mk(4'hE, 0, 0, 7, 2, 0, 0, 13'h5), 0, 1, 0);
    step(mk(0, 0, 0, 7, 2, 1, 1, 0), 0, 1, 0);
    rru = 0;
    foreach (ops[i]) foreach (vals[j]) step(mk(ops[i], j[0], i[0], 4, 0, 0, 0, 13'(j)), vals[j], 1, 0);
    step(mk(4'h4, 1, 0, 0, 2, 0, 0, 13'h1F0), 0, 1, 0);
    step(mk(4'h4, 0, 0, 0, 2, 0, 0, 13'h1F0), 0, 1, 0);
    step(mk(4'h5, 1, 1, 0, 1, 0, 0, 13'hAB), 0, 1, 0);
    step(mk(4'hF, 0, 0, 0, 0, 0, 0, 13'h1ABC), 0, 1, 0);
    step(mk(4'hF, 0, 1, 0, 0, 0, 0, 13'h1ABC), 0, 1, 0);
    for (int e = 0; e < 6; e++) step(mk(0, 0, 0, 3'(e + 1), 1, 0, 4'(e), 0), 32'h777, 1, 0);
    for (int o = 8; o < 12; o++) step(mk(4'(o), 1, 0, 0, 1, 0, 0, 13'h9), 0, 1, 0);
    repeat (600) begin
      ins = {$random(seed), $random(seed)};
      if (ins[62:59] == 4'h0) ins[63] = 1'b0;
      if (ins[62:59] == 4'h0) ins[58] = 1'b0;
      rru = 1'($random(seed)); rrn = ins[52:51];
      step(ins, $random(seed), 1'($random(seed)), ($random(seed) & 63) == 0);
    end
    step(0, 0, 0, 0);
    finish_test();
  end
endmodule // static_switch_instr_decode_tb
